// ### supervisor_pkg.sv
package supervisor_pkg;

	// serial command opcodes
	localparam logic [7:0] OP_LATCH_SET   = 8'h06;
	localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
	localparam logic [3:0] OP_WRITE_LO    = 4'h2;
	localparam logic [3:0] OP_READ_LO     = 4'h3;
	localparam logic [3:0] OP_HI_NIBBLE   = 4'h0;

	// trip threshold programming addresses and data
	localparam logic [7:0] TRIP_RAISE_ADDR   = 8'h01;
	localparam logic [7:0] TRIP_RESTORE_ADDR = 8'h03;
	localparam logic [7:0] TRIP_DATA         = 8'h00;

	// status field positions and reset value
	localparam int         SR_WIP_BIT   = 0;
	localparam int         SR_LATCH_BIT = 1;
	localparam int         SR_BL_LO     = 2;
	localparam int         SR_WD_LO     = 4;
	localparam logic [3:0] NV_DEFAULT   = 4'hC;

	// period select encodings
	localparam logic [1:0] WD_SEL_1400 = 2'h0;
	localparam logic [1:0] WD_SEL_600  = 2'h1;
	localparam logic [1:0] WD_SEL_200  = 2'h2;

	// timing in ms and derived cycle counts at 25 MHz
	localparam int CLK_KHZ       = 25000;
	localparam int RESET_HOLD_MS = 200;
	localparam int WD_1400_MS    = 1400;
	localparam int WD_600_MS     = 600;
	localparam int WD_200_MS     = 200;
	localparam int WRITE_MS      = 5;
	localparam int RESET_HOLD_CYC = RESET_HOLD_MS * CLK_KHZ;
	localparam int WD_1400_CYC    = WD_1400_MS * CLK_KHZ;
	localparam int WD_600_CYC     = WD_600_MS * CLK_KHZ;
	localparam int WD_200_CYC     = WD_200_MS * CLK_KHZ;
	localparam int WRITE_CYC      = WRITE_MS * CLK_KHZ;

	typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_READ} serial_state_t;

	// status of the serial pins after synchronising
	typedef struct packed {
		logic sck;
		logic sel_n;
		logic din;
		logic wp_n;
	} pin_sample_t;

endpackage : supervisor_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of asynchronous pins
module pin_sync
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// pins in, samples out
	input  wire supervisor_pkg::pin_sample_t  raw,
	output      supervisor_pkg::pin_sample_t  sync
);
	supervisor_pkg::pin_sample_t stage1;
	supervisor_pkg::pin_sample_t next_stage1;
	supervisor_pkg::pin_sample_t next_sync;

	// idle values: deselected, clock low, write-protect high
	localparam supervisor_pkg::pin_sample_t pin_idle =
		'{sck: 1'b0, sel_n: 1'b1, din: 1'b0, wp_n: 1'b1};

	always_comb
	begin
		next_stage1 = rst ? pin_idle : raw;
		next_sync   = rst ? pin_idle : stage1;
	end

	// stage1 feeds only the second stage
	always_ff @(posedge clk)
	begin
		stage1 <= next_stage1;
		sync   <= next_sync;
	end

endmodule : pin_sync

// ### supervisor_watchdog_reset.sv
`timescale 1ns/1ps
// Summary of operation
// - select high deselects, output floats
// - deselected means standby unless write busy
// - output bits change on clock falling edge
// - input bits sampled on clock rising edge
// - ignore activity before first select fall
// - write-protect low blocks all nonvolatile writes
// - protect falling during write command aborts
// - started nonvolatile cycle always completes
// - supply low asserts reset, 200ms release
// - power-up holds reset for 200ms
// - select stuck beyond period trips reset
// - each select fall restarts watchdog
// - two retained bits choose watchdog period
// - raise sequence stores zero at location one
// - restore sequence stores zero at three
// - select codes 1.4s, 600ms, 200ms, off
// - writes need write latch set first
module supervisor_watchdog_reset
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// serial pins
	input  wire logic        SEL_KICK_N,
	input  wire logic        SCK,
	input  wire logic        SDI,
	input  wire logic        WRITE_PROTECT_N,
	output      logic        SDO,
	output      logic        SDO_OE,
	// supply monitor and programming
	input  wire logic        SUPPLY_LOW,
	input  wire logic        PROGRAMMING_VOLTAGE,
	output      logic        SYS_RESET,
	output      logic        STANDBY,
	output      logic        NV_BUSY,
	output      logic [1:0]  TRIP_THRESHOLD,
	// array write side effect
	output      logic        ARRAY_WE,
	output      logic [8:0]  ARRAY_ADDR,
	output      logic [7:0]  ARRAY_DATA
);
	supervisor_pkg::pin_sample_t pins;
	supervisor_pkg::pin_sample_t prev;
	supervisor_pkg::pin_sample_t next_prev;
	logic supply_s1, supply_s2, next_supply_s1, next_supply_s2;
	logic prog_s1, prog_s2, next_prog_s1, next_prog_s2;
	// idle pin levels, so no false edge follows reset
	localparam supervisor_pkg::pin_sample_t pin_idle =
		'{sck: 1'b0, sel_n: 1'b1, din: 1'b0, wp_n: 1'b1};

	pin_sync u_sync
	(
		.clk (REF_CLK),
		.rst (SRST),
		.raw ('{sck: SCK, sel_n: SEL_KICK_N, din: SDI, wp_n: WRITE_PROTECT_N}),
		.sync(pins)
	);

	// double registered analog indications
	always_comb
	begin
		next_supply_s1 = SRST ? 1'b1 : SUPPLY_LOW;
		next_supply_s2 = SRST ? 1'b1 : supply_s1;
		next_prog_s1   = SRST ? 1'b0 : PROGRAMMING_VOLTAGE;
		next_prog_s2   = SRST ? 1'b0 : prog_s1;
		next_prev      = SRST ? pin_idle : pins;
	end
	always_ff @(posedge REF_CLK)
	begin
		supply_s1 <= next_supply_s1;
		supply_s2 <= next_supply_s2;
		prog_s1   <= next_prog_s1;
		prog_s2   <= next_prog_s2;
		prev      <= next_prev;
	end

	wire sck_rise = pins.sck & ~prev.sck;
	wire sck_fall = ~pins.sck & prev.sck;
	wire sel_fall = ~pins.sel_n & prev.sel_n;
	wire sel_rise = pins.sel_n & ~prev.sel_n;

	// serial engine state
	supervisor_pkg::serial_state_t state, next_state;
	logic        armed, next_armed;
	logic [2:0]  bitcnt, next_bitcnt;
	logic [7:0]  shreg, next_shreg;
	logic [7:0]  opcode, next_opcode;
	logic [7:0]  addr, next_addr;
	logic        a8, next_a8;
	logic [7:0]  wdata, next_wdata;
	logic        got_data, next_got_data;
	logic        latch, next_latch;
	logic [3:0]  nv_bits = supervisor_pkg::NV_DEFAULT;
	logic [3:0]  next_nv_bits;
	logic [7:0]  outreg, next_outreg;
	logic        busy, next_busy;
	logic [22:0] wcnt, next_wcnt;
	logic        pend_trip, next_pend_trip;
	logic        trip_raise, next_trip_raise;
	logic        progging, next_progging;
	logic [1:0]  trip = 2'h0;
	logic [1:0]  next_trip;
	logic        sdo_r, next_sdo_r, sdo_oe_r, next_sdo_oe_r;
	logic        we_r, next_we_r;
	logic [8:0]  waddr_r, next_waddr_r;
	logic [7:0]  wd_r, next_wd_r;

	// status byte as shifted out to the host
	function automatic logic [7:0] status_byte(input logic [3:0] nv, input logic wl, input logic b);
		status_byte = {2'h0, nv, 2'h0};
		status_byte[supervisor_pkg::SR_LATCH_BIT] = wl;
		status_byte[supervisor_pkg::SR_WIP_BIT]   = b;
	endfunction : status_byte

	wire [7:0] sh_in = {shreg[6:0], pins.din};
	wire       byte_done = sck_rise & (bitcnt == 3'h7);

	always_comb
	begin
		next_state = state; next_armed = armed; next_bitcnt = bitcnt;
		next_shreg = shreg; next_opcode = opcode; next_addr = addr; next_a8 = a8;
		next_wdata = wdata; next_got_data = got_data; next_latch = latch;
		next_nv_bits = nv_bits; next_outreg = outreg; next_busy = busy;
		next_wcnt = wcnt; next_pend_trip = pend_trip; next_trip_raise = trip_raise;
		next_progging = progging; next_trip = trip; next_sdo_r = sdo_r;
		next_sdo_oe_r = ~pins.sel_n & armed;
		next_we_r = 1'b0; next_waddr_r = waddr_r; next_wd_r = wd_r;
		if (sel_fall)
		begin
			next_armed = 1'b1;
			next_state = supervisor_pkg::ST_OPCODE;
			next_bitcnt = 3'h0;
			next_got_data = 1'b0;
		end
		else if (!pins.sel_n && armed)
		begin
			if (sck_rise)
			begin
				next_shreg = sh_in;
				next_bitcnt = bitcnt + 3'h1;
			end
			if (byte_done)
			begin
				case (state)
					supervisor_pkg::ST_OPCODE:
					begin
						next_opcode = sh_in;
						next_a8 = sh_in[3];
						if (sh_in == supervisor_pkg::OP_READ_STATUS)
						begin
							next_outreg = status_byte(nv_bits, latch, busy);
							next_state = supervisor_pkg::ST_READ;
						end
						else if (sh_in == supervisor_pkg::OP_WRITE_STAT)
							next_state = supervisor_pkg::ST_DATA;
						else
							next_state = supervisor_pkg::ST_ADDR;
					end
					supervisor_pkg::ST_ADDR:
					begin
						next_addr = sh_in;
						next_state = supervisor_pkg::ST_DATA;
					end
					supervisor_pkg::ST_DATA:
					begin
						if (!got_data)
							next_wdata = sh_in;
						next_got_data = 1'b1;
					end
					default: next_state = state;
				endcase
			end
			if (sck_fall && state == supervisor_pkg::ST_READ)
			begin
				next_sdo_r = outreg[7];
				next_outreg = {outreg[6:0], outreg[0]};
			end
			if (!pins.wp_n)
				next_got_data = 1'b0;
		end
		// a lone opcode byte leaves the engine waiting for an address
		else if (sel_rise && armed && state == supervisor_pkg::ST_ADDR && bitcnt == 3'h0)
		begin
			if (opcode == supervisor_pkg::OP_LATCH_SET)
				next_latch = 1'b1;
			else if (opcode == supervisor_pkg::OP_LATCH_CLEAR)
				next_latch = 1'b0;
		end
		else if (sel_rise && got_data && latch && pins.wp_n && !busy
			&& bitcnt == 3'h0)
		begin
			next_latch = 1'b0;
			next_busy = 1'b1;
			next_wcnt = 23'(supervisor_pkg::WRITE_CYC);
			if (opcode == supervisor_pkg::OP_WRITE_STAT)
				next_nv_bits = wdata[supervisor_pkg::SR_BL_LO +: 4];
			else if (opcode[7:4] == supervisor_pkg::OP_HI_NIBBLE
				&& opcode[2:0] == supervisor_pkg::OP_WRITE_LO[2:0])
			begin
				next_we_r = 1'b1;
				next_waddr_r = {a8, addr};
				next_wd_r = wdata;
				if (prog_s2 && wdata == supervisor_pkg::TRIP_DATA && !a8
					&& (addr == supervisor_pkg::TRIP_RAISE_ADDR
					|| addr == supervisor_pkg::TRIP_RESTORE_ADDR))
				begin
					next_pend_trip = 1'b1;
					next_trip_raise = (addr == supervisor_pkg::TRIP_RAISE_ADDR);
				end
			end
		end
		if (!pins.wp_n)
			next_latch = 1'b0;
		// a started cycle ignores the protect pin until done
		if (busy)
		begin
			next_wcnt = wcnt - 23'h1;
			if (wcnt == 23'h0)
				next_busy = 1'b0;
		end
		if (pend_trip)
		begin
			next_pend_trip = 1'b0;
			next_progging = 1'b1;
		end
		if (progging && !pins.wp_n)
		begin
			next_progging = 1'b0;
			next_trip = trip_raise ? 2'h2 : 2'h1;
		end
		if (SRST)
		begin
			next_state = supervisor_pkg::ST_OPCODE; next_armed = 1'b0; next_bitcnt = 3'h0;
			next_latch = 1'b0; next_busy = 1'b0; next_got_data = 1'b0;
			next_pend_trip = 1'b0; next_progging = 1'b0; next_sdo_oe_r = 1'b0;
			next_we_r = 1'b0;
		end
	end

	// nonvolatile bits and trip setting survive the synchronous reset
	always_ff @(posedge REF_CLK)
	begin
		state <= next_state; armed <= next_armed; bitcnt <= next_bitcnt;
		shreg <= next_shreg; opcode <= next_opcode; addr <= next_addr; a8 <= next_a8;
		wdata <= next_wdata; got_data <= next_got_data; latch <= next_latch;
		nv_bits <= next_nv_bits; outreg <= next_outreg; busy <= next_busy;
		wcnt <= next_wcnt; pend_trip <= next_pend_trip; trip_raise <= next_trip_raise;
		progging <= next_progging; trip <= next_trip; sdo_r <= next_sdo_r;
		sdo_oe_r <= next_sdo_oe_r; we_r <= next_we_r; waddr_r <= next_waddr_r;
		wd_r <= next_wd_r;
	end

	// watchdog and reset-delay timers on the internal timebase
	logic [25:0] wd_cnt, next_wd_cnt;
	logic [22:0] hold_cnt, next_hold_cnt;
	logic        rst_out, next_rst_out;
	wire  [1:0]  wd_sel = nv_bits[3:2];

	function automatic logic [25:0] wd_limit(input logic [1:0] s);
		if (s == supervisor_pkg::WD_SEL_1400)
			wd_limit = 26'(supervisor_pkg::WD_1400_CYC);
		else if (s == supervisor_pkg::WD_SEL_600)
			wd_limit = 26'(supervisor_pkg::WD_600_CYC);
		else
			wd_limit = 26'(supervisor_pkg::WD_200_CYC);
	endfunction : wd_limit

	always_comb
	begin
		next_wd_cnt = (sel_fall || rst_out) ? 26'h0 : wd_cnt + 26'h1;
		next_hold_cnt = hold_cnt;
		next_rst_out = rst_out;
		if (supply_s2)
		begin
			next_rst_out = 1'b1;
			next_hold_cnt = 23'h0;
		end
		else if (wd_sel != 2'h3 && wd_cnt >= wd_limit(wd_sel))
		begin
			next_rst_out = 1'b1;
			next_hold_cnt = 23'h0;
		end
		else if (rst_out)
		begin
			next_hold_cnt = hold_cnt + 23'h1;
			if (hold_cnt >= 23'(supervisor_pkg::RESET_HOLD_CYC - 1))
				next_rst_out = 1'b0;
		end
		if (SRST)
		begin
			next_wd_cnt = 26'h0;
			next_hold_cnt = 23'h0;
			next_rst_out = 1'b1;
		end
	end
	always_ff @(posedge REF_CLK)
	begin
		wd_cnt <= next_wd_cnt;
		hold_cnt <= next_hold_cnt;
		rst_out <= next_rst_out;
	end

	// registered outputs
	logic standby_r, next_standby_r;
	always_comb next_standby_r = SRST ? 1'b1 : (pins.sel_n & ~busy);
	always_ff @(posedge REF_CLK) standby_r <= next_standby_r;

	assign SDO = sdo_r;
	assign SDO_OE = sdo_oe_r;
	assign SYS_RESET = rst_out;
	assign STANDBY = standby_r;
	assign NV_BUSY = busy;
	assign TRIP_THRESHOLD = trip;
	assign ARRAY_WE = we_r;
	assign ARRAY_ADDR = waddr_r;
	assign ARRAY_DATA = wd_r;

endmodule : supervisor_watchdog_reset

// ### host_spi_model.sv
`timescale 1ns/1ps
// host side of the serial link; the clock idles low between frames
module host_spi_model
(
	// clock
	input  wire logic clk,
	// serial lines
	output      logic sel_n,
	output      logic sck,
	output      logic sdi,
	input  wire logic sdo
);
	// idle levels at time zero
	initial
	begin
		sel_n = 1'b1;
		sck   = 1'b0;
		sdi   = 1'b0;
	end

	// one frame of n bits, msb first; rd keeps the last byte seen
	task automatic frame(input logic [23:0] v, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge clk) #1 sel_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi = v[i];
			repeat (4) @(posedge clk);
			#1 sck = 1'b1;
			repeat (4) @(posedge clk);
			// sampled late in the high half, long after the falling-edge update
			rd = {rd[6:0], sdo};
			#1 sck = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 sel_n = 1'b1;
		sdi = ~sdi; // released line shows no stale value
		repeat (8) @(posedge clk);
	endtask : frame
endmodule : host_spi_model

// ### supervisor_watchdog_reset_sva.sv
`timescale 1ns/1ps
// checker on the top ports of the supervisor
module supervisor_watchdog_reset_sva
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// watched pins
	input wire logic SEL_KICK_N,
	input wire logic SCK,
	input wire logic WRITE_PROTECT_N,
	input wire logic SDO,
	input wire logic SDO_OE,
	input wire logic SUPPLY_LOW,
	input wire logic SYS_RESET,
	input wire logic STANDBY,
	input wire logic NV_BUSY,
	input wire logic ARRAY_WE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	// busy has to run on after a commit
	sequence s_busy_run;
		NV_BUSY [*8];
	endsequence
	property p_commit;
		ARRAY_WE |-> ##[0:1] s_busy_run;
	endproperty
	// the pins reach the commit logic three samples before the strobe shows
	property p_we_gated;
		ARRAY_WE |-> $past(WRITE_PROTECT_N, 3) && $past(SEL_KICK_N, 3);
	endproperty

	// six cycles covers the two-stage sync plus the output register
	AST_DESEL_FLOAT: assert property (SEL_KICK_N [*6] |-> !SDO_OE)
		else $error("output driven while deselected");
	AST_STANDBY_ON: assert property ((SEL_KICK_N && !NV_BUSY) [*6] |-> STANDBY)
		else $error("no standby while idle");
	AST_ACTIVE: assert property (!SEL_KICK_N [*6] |-> !STANDBY)
		else $error("standby while selected");
	AST_SDO_FALL: assert property (SDO_OE && $changed(SDO) |-> !$past(SCK, 3))
		else $error("output changed after a rising clock");
	AST_SUPPLY_RST: assert property (SUPPLY_LOW |-> ##[1:4] SYS_RESET)
		else $error("supply low without reset");
	AST_POR_HOLD: assert property ($fell(SRST) |-> SYS_RESET [*8])
		else $error("reset released early");
	AST_WE_GATED: assert property (p_we_gated)
		else $error("write committed while protected or selected");
	AST_COMMIT: assert property (p_commit)
		else $error("busy too short after commit");
	AST_BUSY_REFUSE: assert property (NV_BUSY && $past(NV_BUSY) |-> !ARRAY_WE)
		else $error("write accepted while busy");
endmodule : supervisor_watchdog_reset_sva

bind supervisor_watchdog_reset supervisor_watchdog_reset_sva chk
(
	.REF_CLK(REF_CLK), .SRST(SRST), .SEL_KICK_N(SEL_KICK_N), .SCK(SCK),
	.WRITE_PROTECT_N(WRITE_PROTECT_N), .SDO(SDO), .SDO_OE(SDO_OE),
	.SUPPLY_LOW(SUPPLY_LOW), .SYS_RESET(SYS_RESET), .STANDBY(STANDBY),
	.NV_BUSY(NV_BUSY), .ARRAY_WE(ARRAY_WE)
);

// ### supervisor_watchdog_reset_tb_top.sv
`timescale 1ns/1ps
module supervisor_watchdog_reset_tb_top;
	// drives and observations
	logic       ref_clk = 1'b0;
	logic       srst    = 1'b1;
	logic       wp_n    = 1'b1;
	logic       low     = 1'b0;
	logic       pv      = 1'b0;
	logic       sel_n, sck, sdi, sdo, sdo_pin, sdo_oe;
	logic       sdo_q   = 1'b0;
	logic       sys_reset, standby, nv_busy, array_we;
	logic [1:0] trip;
	logic [8:0] array_addr;
	logic [7:0] array_data, rd;
	logic [8:0] we_cnt = 9'h000;
	int         err_count   = 0;
	int         comparisons = 0;

	always #20 ref_clk = ~ref_clk;

	// floating output toggles every cycle so a stale value never matches
	assign sdo = sdo_oe ? sdo_pin : ~sdo_q;
	always @(posedge ref_clk) sdo_q <= sdo;
	always @(posedge ref_clk) if (array_we) we_cnt <= we_cnt + 9'h001;

	supervisor_watchdog_reset uut
	(
		.REF_CLK(ref_clk), .SRST(srst), .SEL_KICK_N(sel_n), .SCK(sck), .SDI(sdi),
		.WRITE_PROTECT_N(wp_n), .SDO(sdo_pin), .SDO_OE(sdo_oe), .SUPPLY_LOW(low),
		.PROGRAMMING_VOLTAGE(pv), .SYS_RESET(sys_reset), .STANDBY(standby),
		.NV_BUSY(nv_busy), .TRIP_THRESHOLD(trip), .ARRAY_WE(array_we),
		.ARRAY_ADDR(array_addr), .ARRAY_DATA(array_data)
	);

	host_spi_model host (.clk(ref_clk), .sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo));

	// compare and count
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// the 200 ms release and the busy time are far beyond this run
	initial
	begin
		repeat (10) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge ref_clk);
		check(sys_reset, 9'h001);
		check(sdo_oe, 9'h000);
		check(standby, 9'h001);
		host.frame(24'h00_0500, 16, rd);
		check(rd, 9'h030);
		host.frame(24'h00_0100, 16, rd);
		host.frame(24'h00_0006, 8, rd);
		host.frame(24'h00_0500, 16, rd);
		check(rd, 9'h032);
		// protect low clears the latch and blocks the status write
		@(posedge ref_clk) #1 wp_n = 1'b0;
		host.frame(24'h00_0100, 16, rd);
		@(posedge ref_clk) #1 wp_n = 1'b1;
		host.frame(24'h00_0500, 16, rd);
		check(rd, 9'h030);
		check(we_cnt, 9'h000);
		host.frame(24'h00_0006, 8, rd);
		#1 pv = 1'b1;
		host.frame(24'h02_0100, 24, rd);
		for (int i = 0; i < 50 && we_cnt == 9'h000; i++)
			@(posedge ref_clk);
		if (we_cnt == 9'h000)
		begin
			err_count++;
			wrap_up();
		end
		check(array_addr, 9'h001);
		check(array_data, 9'h000);
		check(nv_busy, 9'h001);
		check(standby, 9'h000);
		host.frame(24'h00_0500, 16, rd);
		check(rd[0], 9'h001);
		@(posedge ref_clk) #1 wp_n = 1'b0;
		pv = 1'b0;
		repeat (8) @(posedge ref_clk);
		check(trip, 9'h002);
		check(nv_busy, 9'h001);
		#1 low = 1'b1;
		repeat (6) @(posedge ref_clk);
		check(sys_reset, 9'h001);
		wrap_up();
	end
endmodule : supervisor_watchdog_reset_tb_top
